//--- cdrb_rx_buffers.sv
// two dedicated receive message buffers with AXI4-Lite register access
// Behaviour
// RULE1: storing a frame sets full; a full buffer accepts nothing more.
// RULE2: software clears full after reading the stored message.
// RULE3: mode 0 accept code 11 takes every frame, errors included, no filtering; the code still routes by filter, buffer 0 taking filters 0-1 only.
// RULE4: mode 0 codes 10 extended only, 01 standard only, 00 per filter select.
// RULE5: modes 1 and 2 mode bit set takes everything; clear takes filtered valid.
// RULE6: read-only remote flag at bit 3 in mode 0, bit 5 otherwise.
// RULE7: mode 0 overflow enable diverts frame to buffer 1 when buffer 0 full.
// RULE8: buffer 0 shows a read-only copy of overflow enable as jump offset.
// RULE9: mode 0 buffer 0 filter bit tells filter 1 or filter 0.
// RULE10: modes 1 and 2 report admitting filter number in five bits.
// RULE11: mode 0 buffer 1 reports filter in three bits, 0 to 5.
// RULE12: identifier bytes hold base or long identifier bits in fixed positions.
// RULE13: low identifier byte bit 3 flags an extended frame.
// RULE14: substitute remote bit reads 0 extended, else the remote flag.
// RULE15: length register bit 6 is frame remote bit; bits 7,5,4 read zero.
// RULE16: length code 0 to 8 valid, 9 to 15 invalid, reported as received.
// RULE17: eight read-only data bytes per buffer, in received order.
// RULE18: eight-bit receive error counter from zero; above 127 means error passive.
// RULE19: the receive error counter never causes bus-off.
// RULE20: software checks full, format, reads fields, then clears full.
// RULE21: writes to read-only fields leave their contents unchanged.
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`include "cdrb_defs.svh"
module cdrb_rx_buffers
   import cdrb_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire cdrb_frame_s rx_frame,
   input wire logic rx_err_inc1,
   input wire logic rx_err_inc8,
   input wire logic rx_ok_dec,
   input wire logic [15:0] filter_extended_select,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic error_passive
);

   initial begin
      if (ADDR_W < 8) $error("address width too small for register map");
      if (ADDR_W > 32) $error("address width beyond the register bus");
   end

   cdrb_slot_s slot_q [2];
   cdrb_mode_e mode_q;
   logic [1:0] accept_mode_q [2];
   logic overflow_to_second_enable_q;
   logic [7:0] rx_error_count_q;

   // acceptance test for one buffer given its mode bits
   function automatic logic accepts(input cdrb_mode_e m, input logic [1:0] am,
                                    input cdrb_frame_s f);
      logic ok;
      ok = 1'b0;
      if (m == CDRB_MODE_LEGACY) begin
         case (am)
            2'b11: ok = 1'b1; // RULE3
            2'b10: ok = !f.erroneous && f.extended; // RULE4
            2'b01: ok = !f.erroneous && !f.extended; // RULE4
            default: ok = !f.erroneous &&
                          (f.extended == filter_extended_select[f.filter[3:0]]); // RULE4
         endcase
      end else begin
         ok = am[1] || !f.erroneous; // RULE5
      end
      return ok;
   endfunction

   // packs an accepted frame into a buffer slot with its full flag set
   function automatic cdrb_slot_s store_slot(input cdrb_frame_s f);
      cdrb_slot_s s;
      s.full = 1'b1;
      s.remote = f.remote;
      s.extended = f.extended;
      s.ident = f.ident;
      s.length = f.length;
      s.filter = f.filter;
      s.data = f.data;
      return s;
   endfunction

   // register select on the low address byte
   function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      return a[7:0] == off;
   endfunction

   // frame routing: buffer 0 admits filters 0-1 in mode 0; buffer 1 the rest
   // take1 excludes take0, so one frame lands in one buffer at most
   logic legacy;
   logic low_filter;
   logic take0;
   logic take1;
   always_comb begin
      legacy = (mode_q == CDRB_MODE_LEGACY);
      low_filter = legacy ? (rx_frame.filter < 5'd2) : 1'b1;
      take0 = rx_frame.valid && low_filter && !slot_q[0].full &&
              accepts(mode_q, accept_mode_q[0], rx_frame); // RULE1
      take1 = rx_frame.valid && !slot_q[1].full && !take0 &&
              accepts(mode_q, accept_mode_q[1], rx_frame) &&
              (legacy ? (!low_filter ||
                         (slot_q[0].full && overflow_to_second_enable_q)) // RULE7
                      : slot_q[0].full);
   end

   // write channel: both address and data must be held before acting
   // aw and w may arrive in either order; the response waits for both
   logic aw_held_q;
   logic w_held_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic wr_fire;
   assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
   assign s_axi_wready = !w_held_q && !s_axi_bvalid;
   assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         aw_held_q <= 1'b0;
         aw_addr_q <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         w_held_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_q <= 1'b1;
         w_data_q <= s_axi_wdata;
         w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held_q <= 1'b0;
      end
   end

   function automatic logic is_known(input logic [ADDR_W-1:0] a);
      logic [7:0] b;
      b = a[7:0];
      return (a[1:0] == 2'b00) &&
             (b <= `CDRB_OFF_OP_MODE ||
              (b >= `CDRB_OFF_BUF0_BASE && b < `CDRB_OFF_BUF0_BASE + 8'h40) ||
              (b >= `CDRB_OFF_BUF1_BASE && b < `CDRB_OFF_BUF1_BASE + 8'h40));
   endfunction

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CDRB_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= is_known(aw_addr_q) ? `CDRB_RESP_OKAY : `CDRB_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   logic wr_lane0;
   logic wr_ctl0;
   logic wr_ctl1;
   logic wr_mode;
   // register bits live in byte lane 0 only; other lanes are ignored
   assign wr_lane0 = wr_fire && w_strb_q[0];
   assign wr_ctl0 = wr_lane0 && addr_is(aw_addr_q, `CDRB_OFF_RX0_CONTROL);
   assign wr_ctl1 = wr_lane0 && addr_is(aw_addr_q, `CDRB_OFF_RX1_CONTROL);
   assign wr_mode = wr_lane0 && addr_is(aw_addr_q, `CDRB_OFF_OP_MODE);

   // software-writable control bits; read-only fields ignore writes
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mode_q <= CDRB_MODE_LEGACY;
         accept_mode_q[0] <= 2'b00;
         accept_mode_q[1] <= 2'b00;
         overflow_to_second_enable_q <= 1'b0;
      end else begin
         if (wr_mode) begin
            case (w_data_q[1:0])
               2'b01: mode_q <= CDRB_MODE_ENH;
               2'b10: mode_q <= CDRB_MODE_FIFO;
               default: mode_q <= CDRB_MODE_LEGACY;
            endcase
         end
         if (wr_ctl0) begin
            accept_mode_q[0][1] <= w_data_q[`CDRB_BIT_MODE_HIGH];
            if (legacy) begin
               accept_mode_q[0][0] <= w_data_q[`CDRB_BIT_MODE_LOW];
               overflow_to_second_enable_q <= w_data_q[`CDRB_BIT_DBL_EN]; // RULE7
            end
         end
         if (wr_ctl1) begin
            accept_mode_q[1][1] <= w_data_q[`CDRB_BIT_MODE_HIGH];
            if (legacy) begin
               accept_mode_q[1][0] <= w_data_q[`CDRB_BIT_MODE_LOW];
            end
         end
      end
   end

   // message slots: store sets full, software write of 0 clears, store wins
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         slot_q[0] <= '0;
         slot_q[1] <= '0;
      end else begin
         if (wr_ctl0 && !w_data_q[`CDRB_BIT_FULL]) begin
            slot_q[0].full <= 1'b0; // RULE2
         end
         if (wr_ctl1 && !w_data_q[`CDRB_BIT_FULL]) begin
            slot_q[1].full <= 1'b0; // RULE2
         end
         if (take0) begin
            slot_q[0] <= store_slot(rx_frame); // RULE1
         end
         if (take1) begin
            slot_q[1] <= store_slot(rx_frame); // RULE1
         end
      end
   end

   // next receive error count: inc8 wins, both ends saturate
   function automatic logic [7:0] rec_next(input logic [7:0] c, input logic inc8,
                                           input logic inc1, input logic dec);
      logic [7:0] n;
      n = c;
      if (inc8) begin
         n = (c > 8'hf7) ? 8'hff : c + 8'h08;
      end else if (inc1) begin
         n = (c == 8'hff) ? 8'hff : c + 8'h01;
      end else if (dec) begin
         if (c > `CDRB_PASSIVE_LIMIT) begin
            n = `CDRB_PASSIVE_RECOVER;
         end else if (c != 8'h00) begin
            n = c - 8'h01;
         end
      end
      return n;
   endfunction

   // receive error counter; no bus-off path from here
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rx_error_count_q <= `CDRB_RESET_BYTE; // RULE18
      end else begin
         rx_error_count_q <= rec_next(rx_error_count_q, rx_err_inc8, rx_err_inc1, rx_ok_dec);
      end
   end

   // registered, so the level trails the count by one cycle
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         error_passive <= 1'b0;
      end else begin
         error_passive <= rx_error_count_q > `CDRB_PASSIVE_LIMIT; // RULE18 RULE19
      end
   end

   // control register view of one buffer
   function automatic logic [7:0] control_view(input int n);
      logic [7:0] v;
      v = 8'h00;
      v[`CDRB_BIT_FULL] = slot_q[n].full;
      v[`CDRB_BIT_MODE_HIGH] = accept_mode_q[n][1];
      if (legacy) begin
         v[`CDRB_BIT_MODE_LOW] = accept_mode_q[n][0];
         v[`CDRB_BIT_RTR_LEGACY] = slot_q[n].remote; // RULE6
         if (n == 0) begin
            v[`CDRB_BIT_DBL_EN] = overflow_to_second_enable_q;
            v[`CDRB_BIT_JUMP] = overflow_to_second_enable_q; // RULE8
            v[0] = slot_q[0].filter[0]; // RULE9
         end else begin
            v[2:0] = slot_q[1].filter[2:0]; // RULE11
         end
      end else begin
         v[`CDRB_BIT_RTR_NEW] = slot_q[n].remote; // RULE6
         v[4:0] = slot_q[n].filter; // RULE10
      end
      return v;
   endfunction

   // message field view at a word index within a buffer window
   function automatic logic [7:0] field_view(input int n, input logic [3:0] idx);
      logic [7:0] v;
      cdrb_slot_s s;
      v = 8'h00;
      s = slot_q[n];
      case (idx)
         `CDRB_IDX_ID_HIGH: v = s.extended ? s.ident[28:21] : s.ident[10:3]; // RULE12
         `CDRB_IDX_ID_LOW: begin
            v[7:5] = s.extended ? s.ident[20:18] : s.ident[2:0]; // RULE12
            v[`CDRB_BIT_SRR] = !s.extended && s.remote; // RULE14
            v[`CDRB_BIT_EXT] = s.extended; // RULE13
            v[1:0] = s.extended ? s.ident[17:16] : 2'b00;
         end
         `CDRB_IDX_EXT_HIGH: v = s.extended ? s.ident[15:8] : 8'h00;
         `CDRB_IDX_EXT_LOW: v = s.extended ? s.ident[7:0] : 8'h00;
         `CDRB_IDX_LENGTH: begin
            v[`CDRB_BIT_LEN_RTR] = s.remote; // RULE15
            v[3:0] = s.length; // RULE16
         end
         default: begin
            if (idx >= `CDRB_IDX_DATA0) begin
               v = s.data[8 * (idx - `CDRB_IDX_DATA0) +: 8]; // RULE17
            end
         end
      endcase
      return v;
   endfunction

   // read channel: one read at a time, answer the cycle after acceptance
   logic [7:0] rd_byte;
   logic [7:0] ra;
   always_comb begin
      ra = s_axi_araddr[7:0];
      rd_byte = 8'h00;
      if (ra == `CDRB_OFF_RX0_CONTROL) begin
         rd_byte = control_view(0);
      end else if (ra == `CDRB_OFF_RX1_CONTROL) begin
         rd_byte = control_view(1);
      end else if (ra == `CDRB_OFF_RX_ERROR_COUNT) begin
         rd_byte = rx_error_count_q;
      end else if (ra == `CDRB_OFF_OP_MODE) begin
         rd_byte = {6'h00, mode_q};
      end else if (ra[7:6] == 2'b01) begin
         rd_byte = field_view(0, ra[5:2]);
      end else if (ra[7:6] == 2'b10) begin
         rd_byte = field_view(1, ra[5:2]);
      end
   end

   // a refused read answers zero so no stored field leaks out with an error
   logic rd_known;
   logic rd_take;
   assign rd_known = is_known(s_axi_araddr);
   assign rd_take = s_axi_arvalid && s_axi_arready;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `CDRB_RESP_OKAY;
      end else if (rd_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_known ? {24'h000000, rd_byte} : 32'h00000000; // RULE21
         s_axi_rresp <= rd_known ? `CDRB_RESP_OKAY : `CDRB_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule // cdrb_rx_buffers

//--- cdrb_defs.svh
// register offsets, field positions and reset values for the receive buffers
`ifndef CDRB_DEFS_SVH
`define CDRB_DEFS_SVH
`define CDRB_OFF_RX0_CONTROL 8'h00
`define CDRB_OFF_RX1_CONTROL 8'h04
`define CDRB_OFF_RX_ERROR_COUNT 8'h08
`define CDRB_OFF_OP_MODE 8'h0c
`define CDRB_OFF_BUF0_BASE 8'h40
`define CDRB_OFF_BUF1_BASE 8'h80
`define CDRB_IDX_ID_HIGH 4'h0
`define CDRB_IDX_ID_LOW 4'h1
`define CDRB_IDX_EXT_HIGH 4'h2
`define CDRB_IDX_EXT_LOW 4'h3
`define CDRB_IDX_LENGTH 4'h4
`define CDRB_IDX_DATA0 4'h8
`define CDRB_BIT_FULL 7
`define CDRB_BIT_MODE_HIGH 6
`define CDRB_BIT_MODE_LOW 5
`define CDRB_BIT_RTR_NEW 5
`define CDRB_BIT_RTR_LEGACY 3
`define CDRB_BIT_DBL_EN 2
`define CDRB_BIT_JUMP 1
`define CDRB_BIT_SRR 4
`define CDRB_BIT_EXT 3
`define CDRB_BIT_LEN_RTR 6
`define CDRB_PASSIVE_LIMIT 8'h7f
`define CDRB_PASSIVE_RECOVER 8'h77
`define CDRB_RESET_BYTE 8'h00
`define CDRB_RESP_OKAY 2'b00
`define CDRB_RESP_SLVERR 2'b10
`endif

//--- cdrb_pkg.sv
// types shared by the dedicated receive buffer block
package cdrb_pkg;
   typedef enum logic [1:0] {CDRB_MODE_LEGACY, CDRB_MODE_ENH, CDRB_MODE_FIFO} cdrb_mode_e;
   typedef struct packed {
      logic valid;
      logic erroneous;
      logic extended;
      logic remote;
      logic [28:0] ident;
      logic [3:0] length;
      logic [4:0] filter;
      logic [63:0] data;
   } cdrb_frame_s;
   typedef struct packed {
      logic full;
      logic remote;
      logic extended;
      logic [28:0] ident;
      logic [3:0] length;
      logic [4:0] filter;
      logic [63:0] data;
   } cdrb_slot_s;
endpackage

//--- cdrb_rx_props.sv
// checker for the receive buffer block ports
`timescale 1ns/100ps
module cdrb_rx_props (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic rx_err_inc1,
   input wire logic rx_err_inc8,
   input wire logic rx_ok_dec,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic error_passive
);
   logic [7:0] cnt_q;
   // shadow of the receive error count
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= 8'h00;
      end else if (rx_err_inc8) begin
         cnt_q <= (cnt_q > 8'hf7) ? 8'hff : cnt_q + 8'h08;
      end else if (rx_err_inc1 && cnt_q != 8'hff) begin
         cnt_q <= cnt_q + 8'h01;
      end else if (rx_ok_dec) begin
         cnt_q <= (cnt_q > 8'h7f) ? 8'h77 : ((cnt_q == 8'h00) ? 8'h00 : cnt_q - 8'h01);
      end
   end
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer missing");
   rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer not released");
   wr_answer_a: assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready))
      else $error("write answer before both channels held");
   aw_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer not released");
   rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   slverr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
      else $error("refused read returned data");
   passive_level_a: assert property (error_passive == ($past(cnt_q) > 8'h7f))
      else $error("error passive level wrong");
endmodule // cdrb_rx_props
bind cdrb_rx_buffers cdrb_rx_props i_props (.sys_clk, .resetn, .rx_err_inc1, .rx_err_inc8,
   .rx_ok_dec, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .error_passive);

//--- cdrb_can_node.sv
// model of the bus nodes sending frames and error events
`timescale 1ns/100ps
module cdrb_can_node
   import cdrb_pkg::*;
(
   input wire logic sys_clk,
   output cdrb_frame_s rx_frame,
   output logic rx_err_inc1,
   output logic rx_err_inc8,
   output logic rx_ok_dec
);
   initial begin
      rx_frame = '0;
      {rx_err_inc8, rx_err_inc1, rx_ok_dec} = 3'b000;
   end
   // flags are erroneous, extended, remote; fields invert once the pulse is over
   task automatic send(input logic [2:0] fl, input logic [28:0] id, input logic [3:0] len,
      input logic [4:0] filt);
      cdrb_frame_s f;
      f = {1'b1, fl, id, len, filt, 64'h0807060504030201};
      @(posedge sys_clk);
      rx_frame <= f;
      f = ~f;
      f.valid = 1'b0;
      @(posedge sys_clk);
      rx_frame <= f;
   endtask
   task automatic pulse(input logic [2:0] k);
      @(posedge sys_clk);
      {rx_err_inc8, rx_err_inc1, rx_ok_dec} <= k;
      @(posedge sys_clk);
      {rx_err_inc8, rx_err_inc1, rx_ok_dec} <= 3'b000;
   endtask
endmodule // cdrb_can_node

//--- cdrb_rx_tb.sv
// register level testbench for the receive buffers
`timescale 1ns/100ps
`include "cdrb_defs.svh"
module testbench
   import cdrb_pkg::*;
;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   cdrb_frame_s rx_frame;
   logic rx_err_inc1, rx_err_inc8, rx_ok_dec, error_passive;
   logic [15:0] filter_extended_select = 16'h0000;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_q;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr_q, br_q;
   int fail_count = 0;
   int tests_run = 0;
   localparam logic [7:0] B0 = `CDRB_OFF_BUF0_BASE;
   localparam logic [7:0] B1 = `CDRB_OFF_BUF1_BASE;
   cdrb_rx_buffers i_dut (.sys_clk, .resetn, .rx_frame, .rx_err_inc1, .rx_err_inc8, .rx_ok_dec,
      .filter_extended_select, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .error_passive);
   cdrb_can_node i_node (.sys_clk, .rx_frame, .rx_err_inc1, .rx_err_inc8, .rx_ok_dec);
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   task finish_test();
      $display("Checks %0d, errors %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      br_q = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd_q = s_axi_rdata;
      rr_q = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task chk(input logic [7:0] a, input logic [7:0] e);
      rd(a);
      cmp($sformatf("reg %h", a), {24'h0, e}, rd_q);
   endtask
   initial begin
      repeat (12) @(posedge sys_clk);
      resetn <= 1'b1;
      chk(8'h00, 8'h00);
      chk(8'h08, 8'h00);
      wr(8'h00, 8'h04);
      chk(8'h00, 8'h06);
      i_node.send(3'b001, 29'h123, 4'h8, 5'd1);
      chk(8'h00, 8'h8f);
      chk(B0, 8'h24);
      chk(B0 + 8'h04, 8'h70);
      chk(B0 + 8'h10, 8'h48);
      for (int m = 0; m < 8; m++) chk(B0 + 8'h20 + 8'(4 * m), 8'(m + 1));
      i_node.send(3'b000, 29'h5a5, 4'h9, 5'd0);
      chk(8'h04, 8'h80);
      chk(B1 + 8'h10, 8'h09);
      i_node.send(3'b000, 29'h7ff, 4'h1, 5'd2);
      chk(B1, 8'hb4);
      wr(B0, 8'hff);
      cmp("wr resp", {30'h0, `CDRB_RESP_OKAY}, {30'h0, br_q});
      chk(B0, 8'h24);
      wr(8'h04, 8'h00);
      i_node.send(3'b000, 29'h7ff, 4'h1, 5'd5);
      chk(8'h04, 8'h85);
      wr(8'h00, 8'h20);
      i_node.send(3'b011, 29'h12345678, 4'h0, 5'd0);
      chk(8'h00, 8'h29);
      wr(8'h00, 8'h40);
      i_node.send(3'b011, 29'h12345678, 4'h0, 5'd0);
      chk(8'h00, 8'hc8);
      chk(B0, 8'h91);
      chk(B0 + 8'h04, 8'ha8);
      chk(B0 + 8'h08, 8'h56);
      chk(B0 + 8'h0c, 8'h78);
      chk(B0 + 8'h10, 8'h40);
      wr(8'h00, 8'h00);
      i_node.send(3'b010, 29'h0, 4'h0, 5'd0);
      chk(8'h00, 8'h08);
      filter_extended_select <= 16'h0001;
      i_node.send(3'b010, 29'h0, 4'h0, 5'd0);
      chk(8'h00, 8'h80);
      wr(8'h00, 8'h60);
      i_node.send(3'b100, 29'h0, 4'h0, 5'd1);
      chk(8'h00, 8'he1);
      wr(8'h0c, 8'h01);
      wr(8'h00, 8'h00);
      wr(8'h04, 8'h00);
      i_node.send(3'b001, 29'h0, 4'h0, 5'd15);
      chk(8'h00, 8'haf);
      i_node.send(3'b100, 29'h0, 4'h0, 5'd3);
      chk(8'h04, 8'h05);
      wr(8'h04, 8'h40);
      i_node.send(3'b100, 29'h0, 4'h0, 5'd3);
      chk(8'h04, 8'hc3);
      wr(8'h0c, 8'h02);
      chk(8'h0c, 8'h02);
      wr(8'h0c, 8'h03);
      chk(8'h0c, 8'h00);
      repeat (16) i_node.pulse(3'b100);
      chk(8'h08, 8'h80);
      cmp("error_passive", 32'h1, {31'h0, error_passive});
      wr(8'h08, 8'h00);
      chk(8'h08, 8'h80);
      i_node.pulse(3'b001);
      chk(8'h08, 8'h77);
      cmp("error_passive", 32'h0, {31'h0, error_passive});
      i_node.pulse(3'b010);
      chk(8'h08, 8'h78);
      s_axi_wstrb <= 4'he;
      wr(8'h00, 8'h00);
      chk(8'h00, 8'ha9);
      s_axi_wstrb <= 4'h1;
      wr(8'h10, 8'h00);
      cmp("unmapped wr resp", {30'h0, `CDRB_RESP_SLVERR}, {30'h0, br_q});
      rd(B0 + 8'h21);
      cmp("unaligned data", 32'h0, rd_q);
      cmp("unaligned resp", {30'h0, `CDRB_RESP_SLVERR}, {30'h0, rr_q});
      rd(8'h10);
      cmp("unmapped resp", {30'h0, `CDRB_RESP_SLVERR}, {30'h0, rr_q});
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      finish_test();
   end
endmodule // testbench
